//--- rtl/vector_into_matrix_pkg.sv
// Shared constants, register map and types for the vector-to-matrix move path.
// Assumes one 100 MHz core clock and a synchronous active-high reset everywhere.
package vector_into_matrix_pkg;

	// ==========================================================
	// Storage geometry
	localparam int VL_MAX_BITS = 256;
	localparam int VL_MAX_BYTES = VL_MAX_BITS / 8;
	localparam int ROW_COUNT = VL_MAX_BYTES;
	localparam int ROW_BITS = 5;
	localparam int WORD_BITS = 32;
	localparam logic [5:0] VL_NARROW_BYTES = 6'h10;
	localparam logic [5:0] VL_WIDE_BYTES = 6'h20;
	localparam logic [31:0] VL_NARROW_ENABLES = 32'h0000FFFF;
	localparam logic [31:0] VL_WIDE_ENABLES = 32'hFFFFFFFF;
	localparam logic [3:0] SEGMENT_LAST_BYTE = 4'hF;

	// ==========================================================
	// Instruction field decode
	localparam logic [2:0] SLICE_REG_PREFIX = 3'h3;
	localparam logic [2:0] GROUP_REG_PREFIX = 3'h2;
	localparam logic [2:0] ESIZE_BYTE = 3'h0;
	localparam logic [2:0] ESIZE_HALF = 3'h1;
	localparam logic [2:0] ESIZE_DOUBLE = 3'h3;
	localparam logic [2:0] ESIZE_QUAD = 3'h4;
	localparam int QUAD_SHIFT = 2;
	localparam int PAIR_SHIFT = 1;
	localparam logic [4:0] QUAD_ALIGN_MASK = 5'h3;
	localparam logic [1:0] SINGLE_LAST_REG = 2'h0;
	localparam logic [1:0] PAIR_LAST_REG = 2'h1;
	localparam logic [1:0] QUAD_LAST_REG = 2'h3;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [4:0] REG_CONTROL = 5'h00;
	localparam logic [4:0] REG_STATUS = 5'h04;
	localparam logic [4:0] REG_WINDOW_SELECT = 5'h08;
	localparam logic [4:0] REG_WINDOW_DATA = 5'h0C;
	localparam logic [4:0] REG_MOVE_COUNT = 5'h10;
	localparam int CTRL_STREAMING_BIT = 0;
	localparam int CTRL_STORAGE_BIT = 1;
	localparam int CTRL_VERSION2_BIT = 2;
	localparam int CTRL_WIDE_VL_BIT = 3;
	localparam logic [3:0] CONTROL_RESET = 4'hC;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ABORT_BIT = 1;
	localparam int STAT_FAULT_LSB = 4;
	localparam int WSEL_ROW_LSB = 8;
	localparam logic [1:0] READ_CAPTURE_PHASE = 2'h1;
	localparam logic [1:0] READ_DONE_PHASE = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {move_single, move_tile_quad, move_array_pair, move_array_quad} move_kind_type;
	typedef enum logic [2:0] {fault_none, fault_no_version2, fault_streaming_off, fault_storage_off,
		fault_length, fault_bad_size} fault_type;

	// Low bits that index inside one element of the given size
	function automatic logic [4:0] size_mask(input logic [2:0] esize_log);
		return 5'((6'h1 << esize_log) - 6'h1);
	endfunction : size_mask

endpackage : vector_into_matrix_pkg

//--- rtl/matrix_row_memory.sv
// Matrix accumulator storage: one row per array vector, byte-enabled writes.
// Assumes a single writer and a single reader on the core clock; read data lag one edge.
`timescale 1ns/10ps
module matrix_row_memory (
	input logic clock,
	input logic reset,
	input logic write_enable,
	input logic [vector_into_matrix_pkg::ROW_BITS-1:0] write_row,
	input logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] write_data,
	input logic [vector_into_matrix_pkg::VL_MAX_BYTES-1:0] write_bytes,
	input logic [vector_into_matrix_pkg::ROW_BITS-1:0] read_row,
	output logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] read_data
);
	logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] rows [vector_into_matrix_pkg::ROW_COUNT];

	// ==========================================================
	// Storage array, contents not reset
	always_ff @(posedge clock) begin
		for (int b = 0; b < vector_into_matrix_pkg::VL_MAX_BYTES; b++) begin
			if (write_enable && write_bytes[b]) begin
				rows[write_row][b*8 +: 8] <= write_data[b*8 +: 8];
			end
		end
	end

	// ==========================================================
	// Registered read port
	always_ff @(posedge clock) begin
		if (reset) begin
			read_data <= '0;
		end else begin
			read_data <= rows[read_row];
		end
	end

endmodule : matrix_row_memory

//--- rtl/slice_index_unit.sv
// Slice and vector-group base arithmetic for the move path.
// Assumes the index register value is stable while the caller samples the outputs.
`timescale 1ns/10ps
module slice_index_unit (
	input vector_into_matrix_pkg::move_kind_type kind,
	input logic [2:0] esize_log,
	input logic wide_vl,
	input logic [31:0] index_value,
	input logic [1:0] two_bit_offset_field,
	input logic one_bit_offset_field,
	input logic [2:0] three_bit_offset_field,
	input logic [3:0] single_offset_field,
	output logic [4:0] base,
	output logic [4:0] stride
);
	logic [5:0] vl_bytes;
	logic [5:0] dim;
	logic [4:0] dim_mask;
	logic [4:0] index_low;
	logic [4:0] quad_offset;
	logic [4:0] single_offset;
	logic [5:0] vstride;
	logic [4:0] vstride_mask;
	logic [4:0] single_base;
	logic [4:0] quad_base;
	logic [4:0] array_base;

	// Only the low bits survive every modulo taken here, all moduli being powers of two
	assign vl_bytes = wide_vl ? vector_into_matrix_pkg::VL_WIDE_BYTES : vector_into_matrix_pkg::VL_NARROW_BYTES;
	assign dim = vl_bytes >> esize_log;
	assign dim_mask = 5'(dim - 6'h1);
	assign index_low = index_value[4:0];
	assign quad_offset = (esize_log == vector_into_matrix_pkg::ESIZE_BYTE) ?
		5'(5'(two_bit_offset_field) << vector_into_matrix_pkg::QUAD_SHIFT) :
		(esize_log == vector_into_matrix_pkg::ESIZE_HALF) ?
		5'(5'(one_bit_offset_field) << vector_into_matrix_pkg::QUAD_SHIFT) : 5'h00;
	assign single_offset = {1'b0, single_offset_field & 4'(vector_into_matrix_pkg::SEGMENT_LAST_BYTE >> esize_log)};
	assign vstride = vl_bytes >> ((kind == vector_into_matrix_pkg::move_array_pair) ?
		vector_into_matrix_pkg::PAIR_SHIFT : vector_into_matrix_pkg::QUAD_SHIFT);
	assign vstride_mask = 5'(vstride - 6'h1);
	assign single_base = (index_low + single_offset) & dim_mask;
	assign quad_base = ((index_low & ~vector_into_matrix_pkg::QUAD_ALIGN_MASK) + quad_offset) & dim_mask;
	assign array_base = (index_low + 5'(three_bit_offset_field)) & vstride_mask;
	assign base = (kind == vector_into_matrix_pkg::move_single) ? single_base :
		(kind == vector_into_matrix_pkg::move_tile_quad) ? quad_base : array_base;
	assign stride = vstride[4:0];

endmodule : slice_index_unit

//--- rtl/vector_to_matrix_array_move.sv
// Vector-to-matrix move engine with its Avalon-MM control and storage window.
// Assumes same-clock combinational read ports on the general, vector and predicate files.
`timescale 1ns/10ps
module vector_to_matrix_array_move (
	input logic clock,
	input logic reset,
	input logic [4:0] address,
	input logic read,
	input logic write,
	input logic [31:0] writedata,
	input logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input logic cmd_valid,
	output logic cmd_ready,
	input vector_into_matrix_pkg::move_kind_type cmd_kind,
	input logic [2:0] element_size,
	input logic vertical,
	input logic [3:0] tile_select_field,
	input logic [1:0] slice_reg_field,
	input logic [1:0] group_reg_field,
	input logic [1:0] two_bit_offset_field,
	input logic one_bit_offset_field,
	input logic [2:0] three_bit_offset_field,
	input logic [3:0] single_offset_field,
	input logic [4:0] source_vector_field,
	input logic [2:0] governing_predicate_field,
	output logic [4:0] greg_index,
	input logic [31:0] greg_data,
	output logic [4:0] vreg_index,
	input logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] vreg_data,
	output logic [2:0] pred_index,
	input logic [vector_into_matrix_pkg::VL_MAX_BYTES-1:0] pred_data,
	input logic async_abort,
	output logic move_done,
	output logic move_fault,
	output vector_into_matrix_pkg::fault_type fault_code
);
	typedef enum {idle, check, run, finish} state_type;

	state_type state;
	state_type next_state;

	// Latched command
	vector_into_matrix_pkg::move_kind_type kind;
	logic [2:0] esize_log;
	logic vert;
	logic [3:0] tile;
	logic [1:0] slice_reg, group_reg, off_two;
	logic off_one;
	logic [2:0] off_three;
	logic [3:0] off_single;
	logic [4:0] src_base;
	logic [2:0] pred_sel;

	// Progress
	logic [4:0] base, stride, elem;
	logic [1:0] reg_step;
	logic aborted;
	vector_into_matrix_pkg::fault_type last_fault;
	logic [31:0] move_count;

	// Software state
	logic [3:0] control;
	logic [4:0] window_row;
	logic [2:0] window_word;
	logic [1:0] read_phase;

	// ==========================================================
	// Helpers
	function automatic logic [31:0] lane_merge(input logic [31:0] old_value, input logic [31:0] new_value,
		input logic [3:0] lanes);
		logic [31:0] result;
		result = old_value;
		for (int l = 0; l < 4; l++) begin
			if (lanes[l]) begin
				result[l*8 +: 8] = new_value[l*8 +: 8];
			end
		end
		return result;
	endfunction : lane_merge

	function automatic logic [31:0] predicate_bytes(input logic [31:0] pred, input logic [2:0] size_log);
		logic [31:0] result;
		logic [4:0] lead;
		result = 32'h00000000;
		lead = 5'h00;
		for (int k = 0; k < vector_into_matrix_pkg::VL_MAX_BYTES; k++) begin
			// Each element is governed by the predicate bit of its lowest byte
			lead = 5'(k) & ~vector_into_matrix_pkg::size_mask(size_log);
			result[k] = pred[lead];
		end
		return result;
	endfunction : predicate_bytes

	// ==========================================================
	// Decode of the incoming command
	logic accept;
	logic [4:0] src_decode;
	assign cmd_ready = (state == idle);
	assign accept = cmd_valid && cmd_ready;
	assign src_decode = (cmd_kind == vector_into_matrix_pkg::move_array_pair) ?
		5'(5'(source_vector_field[3:0]) << vector_into_matrix_pkg::PAIR_SHIFT) :
		(cmd_kind == vector_into_matrix_pkg::move_single) ? source_vector_field :
		5'(5'(source_vector_field[2:0]) << vector_into_matrix_pkg::QUAD_SHIFT);

	// ==========================================================
	// Fault checks, in the order decode then enables then length
	logic wide_vl, is_tile, size_bad;
	vector_into_matrix_pkg::fault_type check_fault;
	assign wide_vl = control[vector_into_matrix_pkg::CTRL_WIDE_VL_BIT];
	assign is_tile = (kind == vector_into_matrix_pkg::move_single) || (kind == vector_into_matrix_pkg::move_tile_quad);
	assign size_bad = is_tile && ((esize_log > vector_into_matrix_pkg::ESIZE_QUAD) ||
		((kind == vector_into_matrix_pkg::move_tile_quad) && (esize_log > vector_into_matrix_pkg::ESIZE_DOUBLE)));
	assign check_fault = ((kind != vector_into_matrix_pkg::move_single) &&
		!control[vector_into_matrix_pkg::CTRL_VERSION2_BIT]) ? vector_into_matrix_pkg::fault_no_version2 :
		size_bad ? vector_into_matrix_pkg::fault_bad_size :
		!control[vector_into_matrix_pkg::CTRL_STREAMING_BIT] ? vector_into_matrix_pkg::fault_streaming_off :
		!control[vector_into_matrix_pkg::CTRL_STORAGE_BIT] ? vector_into_matrix_pkg::fault_storage_off :
		((kind == vector_into_matrix_pkg::move_tile_quad) && (esize_log == vector_into_matrix_pkg::ESIZE_DOUBLE) &&
		!wide_vl) ? vector_into_matrix_pkg::fault_length : vector_into_matrix_pkg::fault_none;

	// ==========================================================
	// Index register select and slice arithmetic
	logic [4:0] calc_base, calc_stride;
	assign greg_index = is_tile ? {vector_into_matrix_pkg::SLICE_REG_PREFIX, slice_reg} :
		{vector_into_matrix_pkg::GROUP_REG_PREFIX, group_reg};

	slice_index_unit slice_calc (
		.kind(kind),
		.esize_log(esize_log),
		.wide_vl(wide_vl),
		.index_value(greg_data),
		.two_bit_offset_field(off_two),
		.one_bit_offset_field(off_one),
		.three_bit_offset_field(off_three),
		.single_offset_field(off_single),
		.base(calc_base),
		.stride(calc_stride)
	);

	// ==========================================================
	// Write datapath
	logic [1:0] last_reg;
	logic [4:0] dim_last, tile_masked, slice_now, pos_bytes, elem_bytes, write_row;
	logic vert_tile, elem_active, last_step, write_enable;
	logic [31:0] vl_enables, row_enables, write_bytes;
	logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] write_data, window_row_data;
	assign last_reg = (kind == vector_into_matrix_pkg::move_single) ? vector_into_matrix_pkg::SINGLE_LAST_REG :
		(kind == vector_into_matrix_pkg::move_array_pair) ? vector_into_matrix_pkg::PAIR_LAST_REG :
		vector_into_matrix_pkg::QUAD_LAST_REG;
	assign dim_last = 5'(((wide_vl ? vector_into_matrix_pkg::VL_WIDE_BYTES : vector_into_matrix_pkg::VL_NARROW_BYTES)
		>> esize_log) - 6'h1);
	assign tile_masked = 5'(tile) & vector_into_matrix_pkg::size_mask(esize_log);
	assign slice_now = base + 5'(reg_step);
	assign pos_bytes = 5'(slice_now << esize_log);
	assign elem_bytes = 5'(elem << esize_log);
	assign vert_tile = vert && is_tile;
	assign vreg_index = src_base + 5'(reg_step);
	assign pred_index = pred_sel;
	// Predicate only governs the single move; multi-register moves are unpredicated
	assign elem_active = (kind != vector_into_matrix_pkg::move_single) || pred_data[elem_bytes];
	assign vl_enables = wide_vl ? vector_into_matrix_pkg::VL_WIDE_ENABLES : vector_into_matrix_pkg::VL_NARROW_ENABLES;
	assign row_enables = (kind == vector_into_matrix_pkg::move_single) ?
		(predicate_bytes(pred_data, esize_log) & vl_enables) : vl_enables;
	assign write_row = !is_tile ? 5'(base + 5'(stride * reg_step)) :
		vert_tile ? (5'(elem << esize_log) | tile_masked) : (5'(slice_now << esize_log) | tile_masked);
	assign write_data = vert_tile ? ((vreg_data >> {elem_bytes, 3'h0}) << {pos_bytes, 3'h0}) : vreg_data;
	assign write_bytes = vert_tile ?
		(elem_active ? (((32'h1 << (32'h1 << esize_log)) - 32'h1) << pos_bytes) : 32'h00000000) :
		row_enables;
	// Inactive elements still take their cycle, so timing never follows the data
	assign write_enable = (state == run) && !async_abort;
	assign last_step = (reg_step == last_reg) && (!vert_tile || (elem == dim_last));

	matrix_row_memory storage (
		.clock(clock),
		.reset(reset),
		.write_enable(write_enable),
		.write_row(write_row),
		.write_data(write_data),
		.write_bytes(write_bytes),
		.read_row(window_row),
		.read_data(window_row_data)
	);

	// ==========================================================
	// Engine state machine
	always_comb begin
		next_state = state;
		case (state)
			idle: begin
				if (accept) begin
					next_state = check;
				end
			end
			check: begin
				next_state = (check_fault == vector_into_matrix_pkg::fault_none) ? run : finish;
			end
			run: begin
				// Abort is taken at the next edge whatever the operands hold
				if (async_abort || last_step) begin
					next_state = finish;
				end
			end
			finish: begin
				next_state = idle;
			end
			default: begin
				next_state = idle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state <= idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			kind <= vector_into_matrix_pkg::move_single;
			esize_log <= vector_into_matrix_pkg::ESIZE_BYTE;
			vert <= 1'b0;
			tile <= 4'h0;
			slice_reg <= 2'h0;
			group_reg <= 2'h0;
			off_two <= 2'h0;
			off_one <= 1'b0;
			off_three <= 3'h0;
			off_single <= 4'h0;
			src_base <= 5'h00;
			pred_sel <= 3'h0;
		end else if (accept) begin
			kind <= cmd_kind;
			esize_log <= element_size;
			vert <= vertical;
			tile <= tile_select_field;
			slice_reg <= slice_reg_field;
			group_reg <= group_reg_field;
			off_two <= two_bit_offset_field;
			off_one <= one_bit_offset_field;
			off_three <= three_bit_offset_field;
			off_single <= single_offset_field;
			src_base <= src_decode;
			pred_sel <= governing_predicate_field;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			base <= 5'h00;
			stride <= 5'h00;
		end else if (state == check) begin
			base <= calc_base;
			stride <= calc_stride;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || (state == check)) begin
			reg_step <= 2'h0;
			elem <= 5'h00;
		end else if (state == run) begin
			if (vert_tile && (elem != dim_last)) begin
				elem <= elem + 5'h01;
			end else begin
				elem <= 5'h00;
				reg_step <= reg_step + 2'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			last_fault <= vector_into_matrix_pkg::fault_none;
			aborted <= 1'b0;
			move_count <= 32'h00000000;
		end else begin
			if (state == check) begin
				last_fault <= check_fault;
				aborted <= 1'b0;
			end
			if ((state == run) && async_abort) begin
				aborted <= 1'b1;
			end
			if ((state == run) && !async_abort && last_step) begin
				move_count <= move_count + 32'h00000001;
			end
		end
	end

	assign move_done = (state == finish);
	assign move_fault = (state == finish) && (last_fault != vector_into_matrix_pkg::fault_none);
	assign fault_code = last_fault;

	// ==========================================================
	// Avalon-MM slave: writes take no wait, reads wait two cycles
	logic [31:0] read_mux, window_select_value, status_value;
	assign window_select_value = 32'(window_word) | (32'(window_row) << vector_into_matrix_pkg::WSEL_ROW_LSB);
	assign status_value = 32'(state != idle) << vector_into_matrix_pkg::STAT_BUSY_BIT |
		32'(aborted) << vector_into_matrix_pkg::STAT_ABORT_BIT |
		32'(last_fault) << vector_into_matrix_pkg::STAT_FAULT_LSB;
	assign read_mux = (address == vector_into_matrix_pkg::REG_CONTROL) ? 32'(control) :
		(address == vector_into_matrix_pkg::REG_STATUS) ? status_value :
		(address == vector_into_matrix_pkg::REG_WINDOW_SELECT) ? window_select_value :
		(address == vector_into_matrix_pkg::REG_WINDOW_DATA) ?
		window_row_data[window_word*vector_into_matrix_pkg::WORD_BITS +: vector_into_matrix_pkg::WORD_BITS] :
		(address == vector_into_matrix_pkg::REG_MOVE_COUNT) ? move_count : 32'h00000000;
	assign waitrequest = read && (read_phase != vector_into_matrix_pkg::READ_DONE_PHASE);

	always_ff @(posedge clock) begin
		if (reset) begin
			read_phase <= 2'h0;
			readdata <= 32'h00000000;
		end else begin
			read_phase <= (read && (read_phase != vector_into_matrix_pkg::READ_DONE_PHASE)) ? read_phase + 2'h1 : 2'h0;
			if (read && (read_phase == vector_into_matrix_pkg::READ_CAPTURE_PHASE)) begin
				readdata <= read_mux;
			end
		end
	end

	logic [31:0] control_merged;
	logic [31:0] window_merged;
	assign control_merged = lane_merge(32'(control), writedata, byteenable);
	assign window_merged = lane_merge(window_select_value, writedata, byteenable);

	always_ff @(posedge clock) begin
		if (reset) begin
			control <= vector_into_matrix_pkg::CONTROL_RESET;
			window_row <= 5'h00;
			window_word <= 3'h0;
		end else if (write && (address == vector_into_matrix_pkg::REG_CONTROL)) begin
			control <= control_merged[3:0];
		end else if (write && (address == vector_into_matrix_pkg::REG_WINDOW_SELECT)) begin
			window_row <= window_merged[vector_into_matrix_pkg::WSEL_ROW_LSB +: vector_into_matrix_pkg::ROW_BITS];
			window_word <= window_merged[2:0];
		end
	end

endmodule : vector_to_matrix_array_move

//--- sim/move_props.sv
// Concurrent checks on the move engine's bus and command ports.
// Assumes the one core clock and the design's synchronous reset.
`timescale 1ns/10ps
module move_props (
	input logic clock,
	input logic reset,
	input logic read,
	input logic write,
	input logic waitrequest,
	input logic cmd_valid,
	input logic cmd_ready,
	input vector_into_matrix_pkg::move_kind_type cmd_kind,
	input logic [1:0] slice_reg_field,
	input logic [1:0] group_reg_field,
	input logic [4:0] greg_index,
	input logic async_abort,
	input logic move_done,
	input logic move_fault,
	input vector_into_matrix_pkg::fault_type fault_code
);
	// ====================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	wire take = cmd_valid && cmd_ready;
	read_wait_a: assert property ($rose(read) |-> waitrequest ##1 waitrequest ##1 !waitrequest) else $error("read wait");
	write_free_a: assert property (write |-> !waitrequest) else $error("write stalled");
	busy_take_a: assert property (take |=> !cmd_ready) else $error("ready after accept");
	done_pulse_a: assert property (move_done |=> !move_done && cmd_ready) else $error("done shape");
	fault_pair_a: assert property (move_fault |-> move_done && fault_code != 3'h0) else $error("fault alone");
	slice_reg_a: assert property (take && cmd_kind == vector_into_matrix_pkg::move_tile_quad
		|=> greg_index == {3'h3, $past(slice_reg_field)}) else $error("slice register");
	group_reg_a: assert property (take && cmd_kind[1] |=> greg_index == {3'h2, $past(group_reg_field)})
		else $error("group register");
	pair_time_a: assert property (take && cmd_kind == vector_into_matrix_pkg::move_array_pair
		##1 !async_abort[*3] |=> move_done || $past(move_fault, 2)) else $error("pair latency");
	quad_time_a: assert property (take && cmd_kind == vector_into_matrix_pkg::move_array_quad
		##1 !async_abort[*5] |=> move_done || $past(move_fault, 4)) else $error("quad latency");
endmodule : move_props
bind vector_to_matrix_array_move move_props i_props (.clock(clock), .reset(reset), .read(read), .write(write),
	.waitrequest(waitrequest), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
	.slice_reg_field(slice_reg_field), .group_reg_field(group_reg_field), .greg_index(greg_index),
	.async_abort(async_abort), .move_done(move_done), .move_fault(move_fault), .fault_code(fault_code));

//--- sim/reg_file_model.sv
// Behavioural general, vector and predicate register files facing the engine.
// Assumes combinational reads; register n of each file holds a value derived from n.
`timescale 1ns/10ps
module reg_file_model (
	input logic [4:0] greg_index,
	output logic [31:0] greg_data,
	input logic [4:0] vreg_index,
	output logic [vector_into_matrix_pkg::VL_MAX_BITS-1:0] vreg_data,
	input logic [2:0] pred_index,
	output logic [vector_into_matrix_pkg::VL_MAX_BYTES-1:0] pred_data
);
	// Index-tagged words show which source landed in which row
	assign greg_data = {27'h0000000, greg_index};
	assign vreg_data = {8{27'h5A5A5A0, vreg_index}};
	assign pred_data = {4{5'h00, pred_index}};
endmodule : reg_file_model

//--- sim/tb.sv
// Self-checking bench: register bus tasks, fault cases and row checks of each move kind.
// Assumes the register file model and the bound checker.
`timescale 1ns/10ps
module tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata, q, greg_data;
	logic waitrequest, cmd_ready, move_done, move_fault;
	logic cmd_valid = 1'b0;
	vector_into_matrix_pkg::move_kind_type cmd_kind = vector_into_matrix_pkg::move_single;
	vector_into_matrix_pkg::fault_type fault_code;
	logic [2:0] element_size = 3'h0;
	logic [3:0] tile_select_field = 4'h0;
	logic [1:0] slice_reg_field = 2'h0;
	logic [1:0] group_reg_field = 2'h0;
	logic [1:0] two_bit_offset_field = 2'h0;
	logic one_bit_offset_field = 1'b0;
	logic [2:0] three_bit_offset_field = 3'h0;
	logic [4:0] source_vector_field = 5'h00;
	logic [4:0] greg_index, vreg_index;
	logic [2:0] pred_index;
	logic [255:0] vreg_data;
	logic [31:0] pred_data;
	int fail_count = 0;
	int checked = 0;
	always #5 clock = ~clock;
	vector_to_matrix_array_move i_dut (.clock(clock), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .element_size(element_size),
		.vertical(1'b0), .tile_select_field(tile_select_field), .slice_reg_field(slice_reg_field),
		.group_reg_field(group_reg_field), .two_bit_offset_field(two_bit_offset_field),
		.one_bit_offset_field(one_bit_offset_field), .three_bit_offset_field(three_bit_offset_field),
		.single_offset_field({1'b0, three_bit_offset_field}), .source_vector_field(source_vector_field),
		.governing_predicate_field(three_bit_offset_field),
		.greg_index(greg_index), .greg_data(greg_data), .vreg_index(vreg_index), .vreg_data(vreg_data),
		.pred_index(pred_index), .pred_data(pred_data), .async_abort(1'b0), .move_done(move_done),
		.move_fault(move_fault), .fault_code(fault_code));
	reg_file_model i_regs (.greg_index(greg_index), .greg_data(greg_data), .vreg_index(vreg_index),
		.vreg_data(vreg_data), .pred_index(pred_index), .pred_data(pred_data));
	// ====================
	// Tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
		@(posedge clock);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		do begin
			@(posedge clock);
		end while (waitrequest !== 1'b0);
		r = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus
	task automatic move(input vector_into_matrix_pkg::move_kind_type k, input logic [2:0] es, input logic [3:0] t,
		input logic [1:0] f, input logic [2:0] o, input logic [4:0] s);
		@(posedge clock);
		cmd_kind <= k;
		element_size <= es;
		tile_select_field <= t;
		slice_reg_field <= f;
		group_reg_field <= f;
		two_bit_offset_field <= o[1:0];
		one_bit_offset_field <= o[0];
		three_bit_offset_field <= o;
		source_vector_field <= s;
		cmd_valid <= 1'b1;
		do begin
			@(posedge clock);
		end while (cmd_ready !== 1'b1);
		cmd_valid <= 1'b0;
		do begin
			@(posedge clock);
		end while (move_done !== 1'b1);
	endtask : move
	task automatic flt(input logic [3:0] c, input vector_into_matrix_pkg::move_kind_type k, input logic [2:0] es,
		input logic [2:0] exp);
		bus(vector_into_matrix_pkg::REG_CONTROL, 1'b1, {28'h0, c}, q);
		move(k, es, 4'h0, 2'h0, 3'h0, 5'h00);
		chk("fault_code", {29'h0, exp}, {29'h0, fault_code});
	endtask : flt
	// Rows are linear in r for every case used, so base and step suffice
	task automatic run(input vector_into_matrix_pkg::move_kind_type k, input logic [2:0] es, input logic [3:0] t,
		input logic [1:0] f, input logic [2:0] o, input logic [4:0] s, input int row, step, vb, nr);
		move(k, es, t, f, o, s);
		chk("fault_code", 32'h0, {29'h0, fault_code});
		for (int r = 0; r < nr; r++) begin
			bus(vector_into_matrix_pkg::REG_WINDOW_SELECT, 1'b1, {19'h0, 5'(row + r * step), 8'h00}, q);
			bus(vector_into_matrix_pkg::REG_WINDOW_DATA, 1'b0, 32'h0, q);
			chk("row word", {27'h5A5A5A0, 5'(vb + r)}, q);
		end
	endtask : run
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	// ====================
	// Sequence
	initial begin
		#100000;
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		bus(vector_into_matrix_pkg::REG_CONTROL, 1'b0, 32'h0, q);
		chk("control reset", 32'hC, q);
		bus(5'h14, 1'b0, 32'h0, q);
		chk("unmapped", 32'h0, q);
		flt(4'hE, vector_into_matrix_pkg::move_array_quad, 3'h3, 3'h2);
		flt(4'hD, vector_into_matrix_pkg::move_array_quad, 3'h3, 3'h3);
		flt(4'hB, vector_into_matrix_pkg::move_array_pair, 3'h3, 3'h1);
		flt(4'h7, vector_into_matrix_pkg::move_tile_quad, 3'h3, 3'h4);
		flt(4'hF, vector_into_matrix_pkg::move_single, 3'h5, 3'h5);
		bus(vector_into_matrix_pkg::REG_STATUS, 1'b0, 32'h0, q);
		chk("status", 32'h50, q);
		run(vector_into_matrix_pkg::move_tile_quad, 3'h0, 4'h0, 2'h1, 3'h3, 5'h05, 24, 1, 20, 4);
		run(vector_into_matrix_pkg::move_tile_quad, 3'h1, 4'h1, 2'h1, 3'h1, 5'h02, 1, 2, 8, 4);
		run(vector_into_matrix_pkg::move_tile_quad, 3'h2, 4'h1, 2'h1, 3'h0, 5'h00, 17, 4, 0, 4);
		run(vector_into_matrix_pkg::move_array_quad, 3'h3, 4'h0, 2'h2, 3'h7, 5'h03, 1, 8, 12, 4);
		run(vector_into_matrix_pkg::move_array_pair, 3'h3, 4'h0, 2'h3, 3'h6, 5'h07, 1, 16, 14, 2);
		// Predicate two leaves byte 0 of row 17 inactive, predicate three makes it active
		run(vector_into_matrix_pkg::move_single, 3'h0, 4'h0, 2'h3, 3'h2, 5'h09, 17, 1, 15, 1);
		run(vector_into_matrix_pkg::move_single, 3'h0, 4'h0, 2'h2, 3'h3, 5'h09, 17, 1, 9, 1);
		bus(vector_into_matrix_pkg::REG_MOVE_COUNT, 1'b0, 32'h0, q);
		chk("move count", 32'h7, q);
		end_sim();
	end
endmodule : tb
